// file: hdl/ptm_map.svh
// Register indices, field positions and reset values of the pulse timing block.
// Included by the top-level design and testbench files; definitions only.
`ifndef PTM_MAP_SVH
`define PTM_MAP_SVH

// Word indices; byte address is index times four
`define PTM_IDX_CR4_START   6'h1b
`define PTM_IDX_CR4_END     6'h1c
`define PTM_IDX_PERIOD_END  6'h1d
`define PTM_IDX_CONTROL     6'h30
`define PTM_IDX_CURRENT     6'h31
`define PTM_IDX_STATUS      6'h32
`define PTM_IDX_COUNT       6'h33

// Control register fields
`define PTM_CTL_TIMER_EN    0
`define PTM_CTL_THIRD_SEL   1
`define PTM_CTL_TXREF_LO    4
`define PTM_CTL_TXREF_HI    5

// Current register fields
`define PTM_CUR_RED_LO      0
`define PTM_CUR_RED_HI      7
`define PTM_CUR_IR_LO       8
`define PTM_CUR_IR_HI       15

// Status register fields
`define PTM_STA_POS_FAULT   0
`define PTM_STA_NEG_FAULT   1
`define PTM_STA_THIRD_SEL   2
`define PTM_STA_CR4_ACTIVE  3

// Reset values: typical 500 Hz settings
`define PTM_RST_CR4_START   16'h1770
`define PTM_RST_CR4_END     16'h1773
`define PTM_RST_PERIOD_END  16'h1f3f
`define PTM_RST_CONTROL     16'h0000
`define PTM_RST_CURRENT     16'h0000

`endif

// file: hdl/ptm_pkg.sv
// Types shared by the pulse timing and emitter drive files.
// Assumes nothing of its surroundings.
package ptm_pkg;

  // Four reference steps: 0.25 V, 0.5 V, 0.75 V, 1 V
  typedef enum logic [1:0] {
    PTM_TXREF_0P25,
    PTM_TXREF_0P50,
    PTM_TXREF_0P75,
    PTM_TXREF_1P00
  } ptm_txref_type;

  typedef struct packed {
    logic pos;
    logic neg;
  } ptm_drive_type;

  typedef struct packed {
    logic pos_fault;
    logic neg_fault;
    logic third_fault;
  } ptm_diag_type;

  typedef struct packed {
    logic          timer_en;
    logic          third_sel;
    ptm_txref_type tx_ref;
  } ptm_cfg_type;

  typedef enum logic [1:0] {
    PTM_BUS_IDLE,
    PTM_BUS_ACK
  } ptm_bus_state_type;

endpackage : ptm_pkg

// file: hdl/ptm_window.sv
// Compare window: a registered pulse while the count lies in [start, end].
// Assumes count, start and end are all on sys_clk.
`timescale 1ns/1ns
module ptm_window #(
  parameter int W = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] count,
  input  wire logic [W-1:0] start_cnt,
  input  wire logic [W-1:0] end_cnt,
  output logic              pulse
);

  logic pulse_q;

  // Start above end yields no pulse at all
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= (start_cnt <= end_cnt) && (count >= start_cnt)
                 && (count <= end_cnt);
    end
  end

  assign pulse = pulse_q;

endmodule : ptm_window

// file: hdl/ptm_emux.sv
// Emitter routing: moves positive-pin drive and its diagnostic to the third pin.
// Assumes requests and diagnostic levels are synchronous to sys_clk.
`timescale 1ns/1ns
module ptm_emux (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic                  third_sel,
  input  wire ptm_pkg::ptm_drive_type drive_req,
  input  wire ptm_pkg::ptm_diag_type  diag_in,
  output ptm_pkg::ptm_drive_type      drive_out,
  output logic                       third_drive,
  output logic                       pos_fault,
  output logic                       neg_fault
);

  ptm_pkg::ptm_drive_type drive_q;
  logic                   third_q;
  logic                   pos_fault_q;
  logic                   neg_fault_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_q <= '0;
      third_q <= 1'b0;
    end else begin
      drive_q.pos <= drive_req.pos & ~third_sel;
      drive_q.neg <= drive_req.neg;
      third_q     <= drive_req.pos & third_sel;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_fault_q <= 1'b0;
      neg_fault_q <= 1'b0;
    end else begin
      pos_fault_q <= third_sel ? diag_in.third_fault : diag_in.pos_fault;
      neg_fault_q <= diag_in.neg_fault;
    end
  end

  assign drive_out   = drive_q;
  assign third_drive = third_q;
  assign pos_fault   = pos_fault_q;
  assign neg_fault   = neg_fault_q;

endmodule : ptm_emux

// file: hdl/ptm_top.sv
// Tail of the pulse timing engine and the digital side of the emitter driver.
// Assumes a classic Wishbone master on sys_clk and drive requests from the
// earlier timing rows arriving synchronous to sys_clk.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ns
`include "ptm_map.svh"

module ptm_top #(
  parameter int CNT_W   = 16,
  parameter int CUR_W   = 8,
  parameter int TCK_DIV = 1
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o,
  input  wire ptm_pkg::ptm_drive_type drive_req,
  input  wire ptm_pkg::ptm_diag_type  diag_in,
  output ptm_pkg::ptm_drive_type      emitter_drive,
  output logic                        third_emitter_pin,
  output logic                        conv_reset_four,
  output logic                        period_end_pulse,
  output logic [CNT_W-1:0]            timing_count,
  output logic [CUR_W-1:0]            red_emitter_current,
  output logic [CUR_W-1:0]            infrared_emitter_current,
  output ptm_pkg::ptm_txref_type      tx_ref_sel
);

  logic [CNT_W-1:0]        conv_reset_four_start_count_q;
  logic [CNT_W-1:0]        conv_reset_four_end_count_q;
  logic [CNT_W-1:0]        period_end_count_q;
  ptm_pkg::ptm_cfg_type    cfg_q;
  logic [CUR_W-1:0]        red_cur_q;
  logic [CUR_W-1:0]        ir_cur_q;
  logic [CNT_W-1:0]        cnt_q;
  logic                    period_end_q;
  logic [15:0]             div_q;
  logic                    tick_q;
  logic                    ack_q;
  logic [31:0]             rdata_q;
  ptm_pkg::ptm_bus_state_type bus_q;
  logic                    cr4_pulse;
  ptm_pkg::ptm_drive_type  drive_w;
  logic                    third_w;
  logic                    pos_fault_w;
  logic                    neg_fault_w;
  logic                    bus_req;
  logic [5:0]              idx;
  logic                    wr_req;
  logic                    wr_cr4_start;
  logic                    wr_cr4_end;
  logic                    wr_period_end;
  logic                    wr_control;
  logic                    wr_current;
  logic                    period_hit;
  logic [CNT_W-1:0]        cnt_inc;
  logic [31:0]             rdata_d;

  // Merge a 16-bit register with byte lanes 0 and 1 of a write
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  sel);
    logic [15:0] r;
    r = old_v;
    if (sel[0]) begin
      r[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = wdat[15:8];
    end
    return r;
  endfunction : lane_merge

  // One decoder for every write strobe
  function automatic logic idx_hit(input logic [5:0] at,
                                   input logic [5:0] code);
    return at == code;
  endfunction : idx_hit

  // Sixteen-bit registers read back zero-extended
  function automatic logic [31:0] pad16(input logic [15:0] v);
    return {16'h0000, v};
  endfunction : pad16

  assign idx     = wb_adr_i[7:2];
  assign bus_req = wb_cyc_i && wb_stb_i && (bus_q == ptm_pkg::PTM_BUS_IDLE);

  // One strobe per register; a write lands on the taken edge, the same edge that raises the ack
  assign wr_req        = bus_req && wb_we_i;
  assign wr_cr4_start  = wr_req && idx_hit(idx, `PTM_IDX_CR4_START);
  assign wr_cr4_end    = wr_req && idx_hit(idx, `PTM_IDX_CR4_END);
  assign wr_period_end = wr_req && idx_hit(idx, `PTM_IDX_PERIOD_END);
  assign wr_control    = wr_req && idx_hit(idx, `PTM_IDX_CONTROL);
  assign wr_current    = wr_req && idx_hit(idx, `PTM_IDX_CURRENT);

  // Wrap on >= so a period end written below the count cannot strand it
  assign period_hit = (cnt_q >= period_end_count_q);
  assign cnt_inc    = cnt_q + CNT_W'(1);

  // Timing clock enable; divide by one runs the engine at sys_clk
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else if (div_q >= 16'(TCK_DIV - 1)) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // Period counter; a period end below the count still wraps at the next tick
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q        <= '0;
      period_end_q <= 1'b0;
    end else if (!cfg_q.timer_en) begin
      cnt_q        <= '0;
      period_end_q <= 1'b0;
    end else if (tick_q) begin
      if (period_hit) begin
        cnt_q        <= '0;
        period_end_q <= 1'b1;
      end else begin
        cnt_q        <= cnt_inc;
        period_end_q <= 1'b0;
      end
    end else begin
      period_end_q <= 1'b0;
    end
  end

  ptm_window #(
    .W (CNT_W)
  ) u_cr4 (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .count     (cnt_q),
    .start_cnt (conv_reset_four_start_count_q),
    .end_cnt   (conv_reset_four_end_count_q),
    .pulse     (cr4_pulse)
  );

  ptm_emux u_emux (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .third_sel   (cfg_q.third_sel),
    .drive_req   (drive_req),
    .diag_in     (diag_in),
    .drive_out   (drive_w),
    .third_drive (third_w),
    .pos_fault   (pos_fault_w),
    .neg_fault   (neg_fault_w)
  );

  // Bus handshake: ack one cycle after the request, then straight back to idle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_q <= ptm_pkg::PTM_BUS_IDLE;
      ack_q <= 1'b0;
    end else begin
      case (bus_q)
        ptm_pkg::PTM_BUS_IDLE: begin
          ack_q <= bus_req;
          if (bus_req) begin
            bus_q <= ptm_pkg::PTM_BUS_ACK;
          end
        end
        ptm_pkg::PTM_BUS_ACK: begin
          ack_q <= 1'b0;
          bus_q <= ptm_pkg::PTM_BUS_IDLE;
        end
        default: begin
          ack_q <= 1'b0;
          bus_q <= ptm_pkg::PTM_BUS_IDLE;
        end
      endcase
    end
  end

  // Count registers; unmapped addresses ack and store nothing
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_reset_four_start_count_q <= `PTM_RST_CR4_START;
    end else if (wr_cr4_start) begin
      conv_reset_four_start_count_q <= lane_merge(conv_reset_four_start_count_q,
                                                  wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_reset_four_end_count_q <= `PTM_RST_CR4_END;
    end else if (wr_cr4_end) begin
      conv_reset_four_end_count_q <= lane_merge(conv_reset_four_end_count_q,
                                                wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      period_end_count_q <= `PTM_RST_PERIOD_END;
    end else if (wr_period_end) begin
      period_end_count_q <= lane_merge(period_end_count_q, wb_dat_i, wb_sel_i);
    end
  end

  // Select bit is taken as written; keeping it static is software's duty
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= '0;
    end else if (wr_control && wb_sel_i[0]) begin
      cfg_q.timer_en  <= wb_dat_i[`PTM_CTL_TIMER_EN];
      cfg_q.third_sel <= wb_dat_i[`PTM_CTL_THIRD_SEL];
      cfg_q.tx_ref    <= ptm_pkg::ptm_txref_type'(
                           wb_dat_i[`PTM_CTL_TXREF_HI:`PTM_CTL_TXREF_LO]);
    end
  end

  // Lane 0 sets red, lane 1 infrared, each on its own
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      red_cur_q <= '0;
    end else if (wr_current && wb_sel_i[0]) begin
      red_cur_q <= wb_dat_i[`PTM_CUR_RED_HI:`PTM_CUR_RED_LO];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ir_cur_q <= '0;
    end else if (wr_current && wb_sel_i[1]) begin
      ir_cur_q <= wb_dat_i[`PTM_CUR_IR_HI:`PTM_CUR_IR_LO];
    end
  end

  // Read word assembled from the index; unmapped words read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (idx)
      `PTM_IDX_CR4_START: begin
        rdata_d = pad16(conv_reset_four_start_count_q);
      end
      `PTM_IDX_CR4_END: begin
        rdata_d = pad16(conv_reset_four_end_count_q);
      end
      `PTM_IDX_PERIOD_END: begin
        rdata_d = pad16(period_end_count_q);
      end
      `PTM_IDX_CONTROL: begin
        rdata_d[`PTM_CTL_TIMER_EN]                   = cfg_q.timer_en;
        rdata_d[`PTM_CTL_THIRD_SEL]                  = cfg_q.third_sel;
        rdata_d[`PTM_CTL_TXREF_HI:`PTM_CTL_TXREF_LO] = cfg_q.tx_ref;
      end
      `PTM_IDX_CURRENT: begin
        rdata_d[`PTM_CUR_RED_HI:`PTM_CUR_RED_LO] = red_cur_q;
        rdata_d[`PTM_CUR_IR_HI:`PTM_CUR_IR_LO]   = ir_cur_q;
      end
      `PTM_IDX_STATUS: begin
        rdata_d[`PTM_STA_POS_FAULT]  = pos_fault_w;
        rdata_d[`PTM_STA_NEG_FAULT]  = neg_fault_w;
        rdata_d[`PTM_STA_THIRD_SEL]  = cfg_q.third_sel;
        rdata_d[`PTM_STA_CR4_ACTIVE] = cr4_pulse;
      end
      `PTM_IDX_COUNT: begin
        rdata_d = pad16(cnt_q);
      end
      default: begin
      end
    endcase
  end

  // Captured at the taken edge and held until the next request
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_req) begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flip-flops here or in the submodules
  assign wb_ack_o                 = ack_q;
  assign wb_dat_o                 = rdata_q;
  assign emitter_drive            = drive_w;
  assign third_emitter_pin        = third_w;
  assign conv_reset_four          = cr4_pulse;
  assign period_end_pulse         = period_end_q;
  assign timing_count             = cnt_q;
  assign red_emitter_current      = red_cur_q;
  assign infrared_emitter_current = ir_cur_q;
  assign tx_ref_sel               = cfg_q.tx_ref;

endmodule : ptm_top

// file: testbench/ptm_top_chk.sv
// Checker for ptm_top: counter, compare window, emitter routing and settings.
// Assumes writes enable both low byte lanes; shadows track the taken edge.
`timescale 1ns/1ns
`include "ptm_map.svh"
module ptm_chk #(
  parameter int CNT_W = 16,
  parameter int CUR_W = 8
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [31:0]            wb_dat_i,
  input  wire logic                   wb_ack_o,
  input  wire ptm_pkg::ptm_drive_type drive_req,
  input  wire ptm_pkg::ptm_drive_type emitter_drive,
  input  wire logic                   third_emitter_pin,
  input  wire logic                   conv_reset_four,
  input  wire logic                   period_end_pulse,
  input  wire logic [CNT_W-1:0]       timing_count,
  input  wire logic [CUR_W-1:0]       red_emitter_current,
  input  wire logic [CUR_W-1:0]       infrared_emitter_current,
  input  wire ptm_pkg::ptm_txref_type tx_ref_sel
);
  logic [15:0] st_q, en_q, pe_q, ctl_q, cur_q;
  logic        wr;
  // Not taken during the ack cycle
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q  <= `PTM_RST_CR4_START;
      en_q  <= `PTM_RST_CR4_END;
      pe_q  <= `PTM_RST_PERIOD_END;
      ctl_q <= `PTM_RST_CONTROL;
      cur_q <= `PTM_RST_CURRENT;
    end else if (wr) begin
      case (wb_adr_i[7:2])
        `PTM_IDX_CR4_START:  st_q <= wb_dat_i[15:0];
        `PTM_IDX_CR4_END:    en_q <= wb_dat_i[15:0];
        `PTM_IDX_PERIOD_END: pe_q <= wb_dat_i[15:0];
        `PTM_IDX_CONTROL:    ctl_q <= wb_dat_i[15:0];
        `PTM_IDX_CURRENT:    cur_q <= wb_dat_i[15:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  AST_WRAP_ZERO: assert property (period_end_pulse |-> timing_count == '0)
    else $error("period pulse without zero count");
  AST_PERIOD_END: assert property (ctl_q[0] && timing_count >= pe_q |=> timing_count == '0)
    else $error("counter did not end period");
  AST_COUNT_STEP: assert property (timing_count != '0 |-> timing_count == $past(timing_count) + 1'b1)
    else $error("counter skipped");
  AST_WRAP_PULSE: assert property ($past(timing_count) != '0 && timing_count == '0 |-> period_end_pulse)
    else $error("wrap without period pulse");
  AST_CR4_ON: assert property (timing_count >= st_q && timing_count <= en_q |=> conv_reset_four)
    else $error("reset pulse missing in window");
  AST_CR4_OFF: assert property (timing_count > en_q || timing_count < st_q |=> !conv_reset_four)
    else $error("reset pulse outside window");
  AST_CR4_EMPTY: assert property (st_q > en_q |=> !conv_reset_four)
    else $error("pulse with start above end");
  AST_POS_ROUTE: assert property (1'b1 |=> emitter_drive.pos == ($past(drive_req.pos) && !$past(ctl_q[1])))
    else $error("positive drive misrouted");
  AST_THIRD_ROUTE: assert property (1'b1 |=> third_emitter_pin == ($past(drive_req.pos) && $past(ctl_q[1])))
    else $error("third drive misrouted");
  AST_CURRENT: assert property ({infrared_emitter_current, red_emitter_current} == cur_q)
    else $error("current setting mismatch");
  AST_TXREF: assert property (tx_ref_sel == ctl_q[5:4])
    else $error("reference setting mismatch");
endmodule : ptm_chk

bind ptm_top ptm_chk #(.CNT_W(CNT_W), .CUR_W(CUR_W)) i_ptm_chk (.sys_clk, .rst_b, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .drive_req, .emitter_drive,
  .third_emitter_pin, .conv_reset_four, .period_end_pulse, .timing_count,
  .red_emitter_current, .infrared_emitter_current, .tx_ref_sel);

// file: testbench/test_ptm_top.sv
// Self-checking bench for ptm_top: registers, timing window, emitter routing.
// Assumes the checker is bound in by its own file; default parameters.
`timescale 1ns/1ns
`include "ptm_map.svh"
module test_ptm_top;
  logic                   sys_clk = 1'b0, rst_b = 1'b0;
  logic                   wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]             wb_adr_i = 8'h00;
  logic [3:0]             wb_sel_i = 4'h3;
  logic [31:0]            wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
  logic [31:0]            rng = 32'h0000_f958;
  logic                   wb_ack_o, third_emitter_pin, conv_reset_four, period_end_pulse;
  ptm_pkg::ptm_drive_type drive_req = '0, emitter_drive;
  ptm_pkg::ptm_diag_type  diag_in = '0;
  logic [15:0]            timing_count;
  logic [7:0]             red_emitter_current, infrared_emitter_current;
  ptm_pkg::ptm_txref_type tx_ref_sel;
  int                     err_count = 0, total_checks = 0, cycles = 0;
  int                     mdl [int];
  int                     tbl [3][3] = '{'{5, 10, 40}, '{39, 40, 40}, '{20, 19, 24}};
  int                     idxs [6] = '{'h1b, 'h1c, 'h1d, 'h30, 'h31, 'h3f};

  ptm_top i_ptm_top (.sys_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .drive_req, .diag_in, .emitter_drive, .third_emitter_pin,
    .conv_reset_four, .period_end_pulse, .timing_count, .red_emitter_current,
    .infrared_emitter_current, .tx_ref_sel);

  always #2 sys_clk = ~sys_clk;

  // A hung handshake or missing pulse ends here
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic we, input int idx, input logic [15:0] dat);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx[5:0], 2'b00};
    wb_dat_i <= {16'h0000, dat};
    do @(negedge sys_clk); while (wb_ack_o !== 1'b1);
    @(posedge sys_clk);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // Model keeps only the bits the register holds; unmapped words stay zero
    if (we && idx != 'h3f) mdl[idx] = (idx == 'h30) ? dat & 16'h0033 : dat;
  endtask : bus

  task automatic run_period();
    int s, e, p, c, prev;
    s = mdl['h1b];
    e = mdl['h1c];
    p = mdl['h1d];
    do @(negedge sys_clk); while (period_end_pulse !== 1'b1);
    for (int k = 0; k <= 2 * (p + 1); k++) begin
      c = k % (p + 1);
      prev = (c == 0) ? p : c - 1;
      chk(timing_count, c);
      chk(period_end_pulse, c == 0);
      chk(conv_reset_four, prev >= s && prev <= e);
      @(negedge sys_clk);
    end
  endtask : run_period

  task automatic wrap_up();
    $display("Checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    mdl['h1b] = `PTM_RST_CR4_START;
    mdl['h1c] = `PTM_RST_CR4_END;
    mdl['h1d] = `PTM_RST_PERIOD_END;
    mdl['h30] = `PTM_RST_CONTROL;
    mdl['h31] = `PTM_RST_CURRENT;
    mdl['h3f] = 0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (idxs[i]) begin
      bus(1'b0, idxs[i], 16'h0000);
      chk(rd, mdl[idxs[i]]);
    end
    bus(1'b1, 'h3f, 16'h5a5a);
    bus(1'b1, 'h30, 16'h0001);
    // First row gives the six-cycle reset width
    for (int t = 0; t < 3; t++) begin
      bus(1'b1, 'h1b, tbl[t][0]);
      bus(1'b1, 'h1c, tbl[t][1]);
      bus(1'b1, 'h1d, tbl[t][2]);
      run_period();
    end
    for (int m = 0; m < 8; m++) begin
      rng = xs(rng);
      bus(1'b1, 'h31, rng[15:0]);
      chk({infrared_emitter_current, red_emitter_current}, rng[15:0]);
      // Select moves only between bursts, never inside one
      bus(1'b1, 'h30, {10'h000, m[1:0], 2'b00, m[2], 1'b1});
      chk(tx_ref_sel, m[1:0]);
      foreach (idxs[i]) begin
        bus(1'b0, idxs[i], 16'h0000);
        chk(rd, mdl[idxs[i]]);
      end
      repeat (4) begin
        rng = xs(rng);
        @(posedge sys_clk);
        drive_req <= rng[1:0];
        diag_in   <= rng[4:2];
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk(emitter_drive, {drive_req.pos & ~m[2], drive_req.neg});
        chk(third_emitter_pin, drive_req.pos & m[2]);
      end
      bus(1'b0, `PTM_IDX_STATUS, 16'h0000);
      // Start above end in the last row: the active bit must stay low
      chk(rd[3:0], {1'b0, m[2], diag_in.neg_fault,
                    m[2] ? diag_in.third_fault : diag_in.pos_fault});
    end
    wrap_up();
  end
endmodule : test_ptm_top
